/* File: design/cefl_pkg.sv */
// package for the converter enable and fault latch supervisor
// assumes a 20 MHz core clock and comparator flags already hysteresis-filtered
package cefl_pkg;
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned CLK_PERIOD_NS = 50;
   // toggle-low time for a latch clear, in microseconds
   localparam int unsigned CLR_LOW_US    = 150;
   localparam int unsigned CLR_LOW_CYC   = (CLR_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   // soft-start reference step time
   localparam int unsigned SS_STEP_US    = 128;
   localparam int unsigned SS_STEP_CYC   = (SS_STEP_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned SS_STEPS      = 7;
   // start-up deglitch window
   localparam int unsigned DEGLITCH_MS   = 3;
   localparam int unsigned DEGLITCH_CYC  = (DEGLITCH_MS * 1_000_000) / CLK_PERIOD_NS;
   // soft-start timeout for reaching secondary bias, microseconds (plain default)
   localparam int unsigned SS_TMO_US     = 2000;
   localparam int unsigned SS_TMO_CYC    = (SS_TMO_US * 1000) / CLK_PERIOD_NS;
   // reference code: 0.9 V start, one 0.4 V step then six 0.2 V steps, in 0.1 V units
   localparam logic [4:0]  VREF_START    = 5'h09;
   localparam logic [4:0]  VREF_FIRST    = 5'h04;
   localparam logic [4:0]  VREF_NEXT     = 5'h02;
   localparam int unsigned SYNC_W        = 11;

   typedef enum logic [4:0] {
      ST_DISABLED = 5'h01,
      ST_SOFTSTART = 5'h02,
      ST_RUN      = 5'h04,
      ST_LOCKOUT  = 5'h08,
      ST_LATCHED  = 5'h10
   } cefl_state_t;

   // comparator flags from the analog front end
   typedef struct packed {
      logic in_low;        // input below lockout falling level
      logic in_analog_low; // input below analog lockout falling level
      logic in_high;       // input above high lockout level
      logic main_low;      // main rail sense below low trip
      logic aux_low;       // aux rail sense below low trip
      logic main_high;     // main rail sense above high trip
      logic aux_high;      // aux rail sense above high trip
      logic failsafe_high; // main rail above failsafe level
      logic bias_ok;       // main rail above secondary bias level
      logic pri_hot;       // primary stage over temperature
      logic sec_hot;       // secondary stage over temperature
   } cefl_flags_t;

   // latched fault causes
   typedef struct packed {
      logic rail_low_trip;
      logic rail_high_trip;
      logic failsafe;
      logic over_temp;
      logic ss_timeout;
   } cefl_fault_t;
endpackage

/* File: design/cefl_top.sv */
// supervisor for enable, power-good and latch-off protection of the converter
// assumes comparator flags and turn_on_request are synchronous-ish single bits
`timescale 1ns/10ps

// How it works
// [RULE1] turn_on_request high starts switching through soft-start to run
// [RULE2] turn_on_request low disables and stops switching
// [RULE3] any latching fault latches off with switching stopped
// [RULE4] turn_on_request low over 150 us then high clears a cleared-cause latch
// [RULE5] power_ok_n pulled low only when faultless and rails within band
// [RULE6] input lockouts auto-recover, all else latches off
// [RULE7] input below analog level then back above lockout clears latch-off
// [RULE8] input below lockout falling level enters lockout, switching stops
// [RULE9] input below analog lockout level resets every protection latch
// [RULE10] after input lockout ends, soft-start if turned on else disabled
// [RULE11] input high lockout stops switching, recovery follows turn-on input
// [RULE12] input high lockout never clears other latches
// [RULE13] either rail below low trip stops, releases power-good, latches
// [RULE14] low trip masked in soft-start, checked when soft-start completes
// [RULE15] either rail above high trip stops at once and latches; code ignores it in soft-start, acts in run only after deglitch
// [RULE16] main rail above failsafe level shuts down and latches
// [RULE17] overload droop is caught by the low trip and latches
// [RULE18] either stage over temperature stops, releases power-good, latches
// [RULE19] temperature latch clears only once cool, by recycle or toggle
// [RULE20] rail trips deglitched 3 ms at start-up before first power-good
// [RULE21] bias level not reached before soft-start timeout shuts down
// [RULE22] reference rises seven 128 us steps: one 0.4 V, six 0.2 V
// [RULE23] comparator flags pass a two-flop synchroniser before use
// [RULE24] reset gives disabled state, clear latches, released power-good
module cefl_top #(
   parameter int unsigned CLR_LOW_CYC  = cefl_pkg::CLR_LOW_CYC,
   parameter int unsigned SS_STEP_CYC  = cefl_pkg::SS_STEP_CYC,
   parameter int unsigned DEGLITCH_CYC = cefl_pkg::DEGLITCH_CYC,
   parameter int unsigned SS_TMO_CYC   = cefl_pkg::SS_TMO_CYC
) (
   // clock and reset
   input  wire logic                  i_mclk,
   input  wire logic                  i_rst,
   // controller side
   input  wire logic                  i_turn_on_request,
   output logic                       o_power_ok_n_out,
   output logic                       o_power_ok_n_oe_n,
   // analog comparators
   input  wire cefl_pkg::cefl_flags_t i_flags,
   // power stage control and status
   output logic                       o_switch_en,
   output logic [4:0]                 o_vref_code,
   output cefl_pkg::cefl_state_t      o_state,
   output cefl_pkg::cefl_fault_t      o_fault
);
   localparam int unsigned SW = cefl_pkg::SYNC_W + 1;

   logic [SW-1:0]          sync1;
   logic [SW-1:0]          sync2;
   logic [SW-1:0]          raw_in;
   cefl_pkg::cefl_flags_t  fl;
   logic                   on_req;
   logic                   on_prev;
   logic [31:0]            low_cnt;
   logic                   toggle_ok;
   logic                   clr_toggle;
   logic                   analog_seen;
   logic                   clr_recycle;
   cefl_pkg::cefl_state_t  state;
   cefl_pkg::cefl_state_t  next_state;
   logic [31:0]            step_cnt;
   logic [2:0]             step_idx;
   logic                   ss_done;
   logic [31:0]            tmo_cnt;
   logic [31:0]            dg_cnt;
   logic                   good_seen;
   logic                   rail_low;
   logic                   rail_high;
   logic                   rail_bad;
   logic                   trip_allowed;
   cefl_pkg::cefl_fault_t  fault;
   logic                   any_fault;
   logic                   in_lock;

   assign raw_in = {i_turn_on_request, i_flags};

   // two-flop synchroniser on every comparator flag and the turn-on input
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= raw_in; // [RULE23]
         sync2 <= sync1;
      end
   end
   assign fl     = sync2[SW-2:0];
   assign on_req = sync2[SW-1];

   assign in_lock   = fl.in_low || fl.in_high;
   assign rail_low  = fl.main_low || fl.aux_low;
   assign rail_high = fl.main_high || fl.aux_high;
   assign rail_bad  = rail_low || rail_high;

   // turn-on low time measured for the latch-clear toggle
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         low_cnt   <= '0;
         toggle_ok <= 1'b0;
         on_prev   <= 1'b0;
      end else begin
         on_prev <= on_req;
         if (on_req) begin
            low_cnt <= '0;
         end else begin
            if (low_cnt < 32'(CLR_LOW_CYC)) begin
               low_cnt <= low_cnt + 32'h1;
            end
         end
         if (on_req && !on_prev) begin
            toggle_ok <= 1'b0;
         end else if (!on_req && low_cnt >= 32'(CLR_LOW_CYC) - 32'h1) begin
            toggle_ok <= 1'b1; // [RULE4]
         end
      end
   end
   assign clr_toggle = on_req && !on_prev && toggle_ok; // [RULE4]

   // input recycle: analog level seen, then input back above lockout
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         analog_seen <= 1'b0;
      end else if (fl.in_analog_low) begin
         analog_seen <= 1'b1;
      end else if (!fl.in_low) begin
         analog_seen <= 1'b0;
      end
   end
   assign clr_recycle = analog_seen && !fl.in_low && !fl.in_analog_low; // [RULE7]

   // soft-start reference stepping and timeout
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         step_cnt <= '0;
         step_idx <= '0;
         ss_done  <= 1'b0;
         tmo_cnt  <= '0;
      end else if (state != cefl_pkg::ST_SOFTSTART) begin
         step_cnt <= '0;
         step_idx <= '0;
         ss_done  <= 1'b0;
         tmo_cnt  <= '0;
      end else begin
         if (tmo_cnt < 32'(SS_TMO_CYC)) begin
            tmo_cnt <= tmo_cnt + 32'h1;
         end
         if (fl.bias_ok && !ss_done) begin
            if (step_cnt >= 32'(SS_STEP_CYC) - 32'h1) begin
               step_cnt <= '0;
               if (step_idx == 3'(cefl_pkg::SS_STEPS - 1)) begin
                  ss_done <= 1'b1; // [RULE22]
               end else begin
                  step_idx <= step_idx + 3'h1;
               end
            end else begin
               step_cnt <= step_cnt + 32'h1;
            end
         end
      end
   end

   // reference code driven to the analog loop
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_vref_code <= cefl_pkg::VREF_START;
      end else if (state == cefl_pkg::ST_RUN) begin
         o_vref_code <= cefl_pkg::VREF_START + cefl_pkg::VREF_FIRST
                        + 5'(6 * cefl_pkg::VREF_NEXT);
      end else if (state == cefl_pkg::ST_SOFTSTART && fl.bias_ok) begin
         // first step 0.4 V, each later one 0.2 V [RULE22]
         o_vref_code <= cefl_pkg::VREF_START + cefl_pkg::VREF_FIRST
                        + 5'(step_idx * cefl_pkg::VREF_NEXT);
      end else begin
         o_vref_code <= cefl_pkg::VREF_START;
      end
   end

   // start-up deglitch until the first power-good
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         dg_cnt    <= '0;
         good_seen <= 1'b0;
      end else if (state != cefl_pkg::ST_RUN) begin
         dg_cnt    <= '0;
         good_seen <= 1'b0;
      end else if (!good_seen) begin
         if (dg_cnt >= 32'(DEGLITCH_CYC) - 32'h1) begin
            good_seen <= 1'b1; // [RULE20]
         end else begin
            dg_cnt <= dg_cnt + 32'h1;
         end
      end
   end
   // rail trips in run only act once the deglitch window has passed
   assign trip_allowed = (state == cefl_pkg::ST_RUN) && good_seen; // [RULE20]

   // protection latches; reset by the analog level, or by a toggle or recycle when latched
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         fault <= '0; // [RULE24]
      end else if (fl.in_analog_low) begin
         fault <= '0; // [RULE9]
      end else if ((clr_toggle || clr_recycle) && state == cefl_pkg::ST_LATCHED
                   && !(fl.pri_hot || fl.sec_hot) && !rail_high && !fl.failsafe_high) begin
         fault <= '0; // [RULE4] [RULE7] [RULE19]
      end else if (state == cefl_pkg::ST_SOFTSTART || state == cefl_pkg::ST_RUN) begin
         // low trip covers overload droop too [RULE13] [RULE17]
         if ((trip_allowed && rail_low) || (ss_done && rail_low)) begin
            fault.rail_low_trip <= 1'b1; // [RULE14]
         end
         if (trip_allowed && rail_high) begin
            fault.rail_high_trip <= 1'b1; // [RULE15]
         end
         if (fl.failsafe_high) begin
            fault.failsafe <= 1'b1; // [RULE16]
         end
         if (fl.pri_hot || fl.sec_hot) begin
            fault.over_temp <= 1'b1; // [RULE18]
         end
         if (state == cefl_pkg::ST_SOFTSTART && !fl.bias_ok
             && tmo_cnt >= 32'(SS_TMO_CYC)) begin
            fault.ss_timeout <= 1'b1; // [RULE21]
         end
      end
   end
   assign any_fault = |fault;

   // operating mode
   always_comb begin
      next_state = state;
      unique case (state)
         cefl_pkg::ST_DISABLED: begin
            if (in_lock) begin
               next_state = cefl_pkg::ST_LOCKOUT; // [RULE8] [RULE11]
            end else if (on_req) begin
               next_state = cefl_pkg::ST_SOFTSTART; // [RULE1]
            end
         end
         cefl_pkg::ST_SOFTSTART, cefl_pkg::ST_RUN: begin
            if (in_lock) begin
               next_state = cefl_pkg::ST_LOCKOUT; // [RULE6] [RULE8] [RULE11]
            end else if (any_fault) begin
               next_state = cefl_pkg::ST_LATCHED; // [RULE3] [RULE6]
            end else if (!on_req) begin
               next_state = cefl_pkg::ST_DISABLED; // [RULE2]
            end else if (state == cefl_pkg::ST_SOFTSTART && ss_done && !rail_low) begin
               next_state = cefl_pkg::ST_RUN; // [RULE1]
            end
         end
         cefl_pkg::ST_LOCKOUT: begin
            // leaving high lockout keeps latched faults [RULE12]
            if (!in_lock) begin
               if (any_fault) begin
                  next_state = cefl_pkg::ST_LATCHED;
               end else if (on_req) begin
                  next_state = cefl_pkg::ST_SOFTSTART; // [RULE10] [RULE11]
               end else begin
                  next_state = cefl_pkg::ST_DISABLED; // [RULE10]
               end
            end
         end
         cefl_pkg::ST_LATCHED: begin
            if (in_lock) begin
               next_state = cefl_pkg::ST_LOCKOUT;
            end else if (!any_fault) begin
               next_state = on_req ? cefl_pkg::ST_SOFTSTART : cefl_pkg::ST_DISABLED; // [RULE19]
            end
         end
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state <= cefl_pkg::ST_DISABLED; // [RULE24]
      end else begin
         state <= next_state;
      end
   end

   // registered outputs
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_switch_en       <= 1'b0;
         o_power_ok_n_oe_n <= 1'b1; // [RULE24]
      end else begin
         o_switch_en <= (next_state == cefl_pkg::ST_SOFTSTART
                         || next_state == cefl_pkg::ST_RUN); // [RULE3] [RULE8]
         // pull low only with no fault and rails in band [RULE5]
         // a fault latching on this same edge releases the pin too
         o_power_ok_n_oe_n <= !(next_state == cefl_pkg::ST_RUN && good_seen
                                && !any_fault && !rail_bad && !fl.failsafe_high
                                && !fl.pri_hot && !fl.sec_hot);
      end
   end
   assign o_power_ok_n_out = 1'b0;
   assign o_state          = state;
   assign o_fault          = fault;
endmodule

/* File: dv/cefl_monitor.sv */
// checker for the converter enable and fault latch supervisor
// bound to cefl_top; one clock domain, reset active high
`timescale 1ns/10ps
module cefl_monitor (
   // watched ports
   input wire logic                  i_mclk,
   input wire logic                  i_rst,
   input wire logic                  i_turn_on_request,
   input wire logic                  o_power_ok_n_out,
   input wire logic                  o_power_ok_n_oe_n,
   input wire cefl_pkg::cefl_flags_t i_flags,
   input wire logic                  o_switch_en,
   input wire logic [4:0]            o_vref_code,
   input wire cefl_pkg::cefl_state_t o_state,
   input wire cefl_pkg::cefl_fault_t o_fault
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic on;
   assign on = o_state inside {cefl_pkg::ST_SOFTSTART, cefl_pkg::ST_RUN};

   a_switch_on_state: assert property (o_switch_en == on)
      else $error("switching outside soft-start or run");
   a_pg_run_only: assert property (!o_power_ok_n_oe_n |-> o_state == cefl_pkg::ST_RUN
      && o_fault == '0 && o_power_ok_n_out == 1'b0) else $error("power good out of run");
   a_pg_deglitch: assert property ($fell(o_power_ok_n_oe_n)
      |-> $past(o_state, 8) == cefl_pkg::ST_RUN) else $error("power good before deglitch");
   a_off_stops: assert property (!i_turn_on_request[*3] |=> !o_switch_en)
      else $error("switching after turn-off");
   a_high_lockout: assert property (i_flags.in_high[*3]
      |=> o_state == cefl_pkg::ST_LOCKOUT) else $error("no high lockout");
   a_low_lockout: assert property (i_flags.in_low[*3]
      |=> o_state == cefl_pkg::ST_LOCKOUT) else $error("no low lockout");
   a_analog_clear: assert property (i_flags.in_analog_low[*3] |=> o_fault == '0)
      else $error("faults kept in analog lockout");
   a_failsafe_latch: assert property ((on && i_flags.failsafe_high && !i_flags.in_low
      && !i_flags.in_high)[*3] |=> o_fault.failsafe) else $error("failsafe not latched");
   a_hot_latch: assert property ((on && (i_flags.pri_hot || i_flags.sec_hot)
      && !i_flags.in_low && !i_flags.in_high)[*3] |=> o_fault.over_temp)
      else $error("over temperature not latched");
   a_vref_step: assert property (o_state == cefl_pkg::ST_SOFTSTART
      && $past(o_state) == cefl_pkg::ST_SOFTSTART && $changed(o_vref_code)
      |-> o_vref_code == $past(o_vref_code) + 5'h02 || o_vref_code == 5'h0D)
      else $error("bad reference step");
   a_reset_idle: assert property (disable iff (1'b0) i_rst |-> o_state ==
      cefl_pkg::ST_DISABLED && o_fault == '0 && o_power_ok_n_oe_n) else $error("bad reset");
endmodule

bind cefl_top cefl_monitor i_cefl_monitor (
   .i_mclk           (i_mclk),
   .i_rst            (i_rst),
   .i_turn_on_request(i_turn_on_request),
   .o_power_ok_n_out (o_power_ok_n_out),
   .o_power_ok_n_oe_n(o_power_ok_n_oe_n),
   .i_flags          (i_flags),
   .o_switch_en      (o_switch_en),
   .o_vref_code      (o_vref_code),
   .o_state          (o_state),
   .o_fault          (o_fault)
);

/* File: dv/cefl_ctrl_model.sv */
// system controller model: drives turn-on, reads the power-good pin
// pin has a pull-up, so a released pin reads high
`timescale 1ns/10ps
module cefl_ctrl_model #(
   parameter int unsigned LOW_CYC = 20
) (
   // bench side
   input  wire logic i_mclk,
   input  wire logic i_want_on,
   input  wire logic i_toggle,
   output logic      o_power_good,
   // device side
   input  wire logic i_pin_out,
   input  wire logic i_pin_oe_n,
   output logic      o_turn_on_request
);
   int unsigned low_cnt = 0;
   assign o_power_good = i_pin_oe_n ? 1'b0 : !i_pin_out;
   // clear toggle holds turn-on low beyond the clear time
   always_ff @(posedge i_mclk) begin
      if (i_toggle)
         low_cnt <= LOW_CYC + 4;
      else if (low_cnt != 0)
         low_cnt <= low_cnt - 1;
   end
   assign o_turn_on_request = i_want_on && low_cnt == 0;
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the enable and fault latch supervisor
// flags driven directly; turn-on comes from the controller model
`timescale 1ns/10ps
module testbench;
   localparam cefl_pkg::cefl_state_t DIS = cefl_pkg::ST_DISABLED;
   localparam cefl_pkg::cefl_state_t SS  = cefl_pkg::ST_SOFTSTART;
   localparam cefl_pkg::cefl_state_t RUN = cefl_pkg::ST_RUN;
   localparam cefl_pkg::cefl_state_t LCK = cefl_pkg::ST_LOCKOUT;
   localparam cefl_pkg::cefl_state_t LAT = cefl_pkg::ST_LATCHED;
   logic                  i_mclk  = 1'b0;
   logic                  i_rst   = 1'b0;
   logic                  want_on = 1'b0;
   logic                  toggle  = 1'b0;
   logic                  turn_on, pg, pin_out, pin_oe_n, sw;
   logic [4:0]            vref;
   cefl_pkg::cefl_flags_t flags = 11'h004;
   cefl_pkg::cefl_state_t st;
   cefl_pkg::cefl_fault_t flt;
   int                    fail_count = 0;
   int                    tests_run  = 0;

   cefl_top #(.CLR_LOW_CYC(20), .SS_STEP_CYC(4), .DEGLITCH_CYC(10), .SS_TMO_CYC(100)) i_cefl_top (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_turn_on_request(turn_on),
      .o_power_ok_n_out(pin_out), .o_power_ok_n_oe_n(pin_oe_n), .i_flags(flags),
      .o_switch_en(sw), .o_vref_code(vref), .o_state(st), .o_fault(flt));
   cefl_ctrl_model #(.LOW_CYC(20)) i_cefl_ctrl_model (
      .i_mclk(i_mclk), .i_want_on(want_on), .i_toggle(toggle), .o_power_good(pg),
      .i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n), .o_turn_on_request(turn_on));

   initial begin
      forever #25 i_mclk = ~i_mclk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(string n, logic [4:0] e, logic [4:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic step(int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask

   task automatic wait_st(cefl_pkg::cefl_state_t s, int lim);
      for (int k = 0; k < lim && st !== s; k++) step(1);
      chk("state", s, st);
      if (st !== s) conclude();
   endtask

   task automatic toggle_clr();
      toggle = 1'b1;
      step(1);
      toggle = 1'b0;
      step(30);
   endtask

   task automatic go_run();
      want_on = 1'b1;
      wait_st(RUN, 80);
      for (int k = 0; k < 20 && pg !== 1'b1; k++) step(1);
      chk("pg", 5'h01, pg);
   endtask

   task automatic sc_start();
      chk("pg", 5'h00, pg);
      want_on = 1'b1;
      wait_st(SS, 6);
      chk("switch", 5'h01, sw);
      for (int k = 0; k < 8 && vref === 5'h09; k++) step(1);
      chk("vref", 5'h0D, vref);
      wait_st(RUN, 40);
      chk("vref", 5'h19, vref);
      chk("pg", 5'h00, pg);
      step(12);
      chk("pg", 5'h01, pg);
      want_on = 1'b0;
      wait_st(DIS, 6);
      chk("switch", 5'h00, sw);
      chk("pg", 5'h00, pg);
   endtask

   task automatic sc_faults();
      int         idx[5]   = '{7, 4, 3, 1, 0};
      logic [4:0] cause[5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h02};
      for (int i = 0; i < 5; i++) begin
         go_run();
         flags[idx[i]] = 1'b1;
         wait_st(LAT, 6);
         chk("fault", cause[i], flt);
         chk("pg", 5'h00, pg);
         if (i > 0) begin
            toggle_clr();
            chk("state", LAT, st);
         end
         flags[idx[i]] = 1'b0;
         step(8);
         chk("state", LAT, st);
         toggle_clr();
         wait_st(RUN, 40);
      end
   endtask

   task automatic sc_lockout();
      go_run();
      flags.in_high = 1'b1;
      wait_st(LCK, 6);
      chk("switch", 5'h00, sw);
      flags.in_high = 1'b0;
      wait_st(SS, 6);
      flags.failsafe_high = 1'b1;
      wait_st(LAT, 6);
      flags.failsafe_high = 1'b0;
      flags.in_high = 1'b1;
      wait_st(LCK, 6);
      flags.in_high = 1'b0;
      wait_st(LAT, 6);
      chk("fault", 5'h04, flt);
      flags.in_low = 1'b1;
      flags.in_analog_low = 1'b1;
      wait_st(LCK, 6);
      step(4);
      chk("fault", 5'h00, flt);
      flags.in_analog_low = 1'b0;
      flags.in_low = 1'b0;
      wait_st(SS, 6);
      want_on = 1'b0;
      flags.in_low = 1'b1;
      wait_st(LCK, 6);
      flags.in_low = 1'b0;
      wait_st(DIS, 6);
   endtask

   task automatic sc_softstart();
      flags.bias_ok = 1'b0;
      want_on = 1'b1;
      wait_st(SS, 6);
      step(20);
      chk("vref", 5'h09, vref);
      wait_st(LAT, 110);
      chk("fault", 5'h01, flt);
      flags.bias_ok = 1'b1;
      flags.aux_low = 1'b1;
      toggle_clr();
      chk("state", SS, st);
      wait_st(LAT, 40);
      chk("fault", 5'h10, flt);
      flags.aux_low = 1'b0;
   endtask

   initial begin
      // reset edge before the first clock, so no register starts unknown
      #1;
      i_rst = 1'b1;
      step(20);
      i_rst = 1'b0;
      sc_start();
      sc_faults();
      sc_lockout();
      sc_softstart();
      i_rst = 1'b1;
      step(2);
      chk("state", DIS, st);
      conclude();
   end
endmodule
